/* File: core/nrp_pkg.sv */
// Purpose: shared constants and types for the byte-wide read-only ROM
//          host controller
// Assumes: aclk at 125 MHz; device timing figures are in nanoseconds
// Notes:   every count is derived from its time and the clock period
package nrp_pkg;

  localparam int CLK_NS = 8;

  // device timing, figures as printed
  localparam int T_WP_NS  = 25;   // write pulse width, least
  localparam int T_WC_NS  = 50;   // write cycle time, least
  localparam int T_RP_NS  = 35;   // read pulse width, least
  localparam int T_REH_NS = 15;   // output strobe high hold, least
  localparam int T_WB_NS  = 200;  // input strobe high to busy, longest
  localparam int T_RB_NS  = 200;  // last strobe to busy, longest
  localparam int T_RR_NS  = 20;   // ready to output strobe low, least
  localparam int T_R_NS   = 7000; // array fetch time, longest

  localparam int SYNC_CYC = 2;    // pin synchroniser latency

  // cycle counts: least times round up, the busy window is a wait floor
  localparam logic [9:0] C_WP  = 10'((T_WP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [9:0] C_WH  =
    10'((T_WC_NS + CLK_NS - 1) / CLK_NS - (T_WP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [9:0] C_RE  =
    10'((T_RP_NS + CLK_NS - 1) / CLK_NS + SYNC_CYC);
  localparam logic [9:0] C_REH = 10'((T_REH_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [9:0] C_WB  = 10'((T_WB_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [9:0] C_RB  = 10'((T_RB_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [9:0] C_RR  = 10'((T_RR_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [9:0] C_R   = 10'(T_R_NS / CLK_NS);

  // command codes on the shared bus
  localparam logic [7:0] CMD_READ_A = 8'h00;
  localparam logic [7:0] CMD_READ_B = 8'h01;
  localparam logic [7:0] CMD_READ_C = 8'h50;
  localparam logic [7:0] CMD_RESET  = 8'hFF;

  // host operations written to the command register
  localparam logic [2:0] OP_RD_A  = 3'h0;
  localparam logic [2:0] OP_RD_B  = 3'h1;
  localparam logic [2:0] OP_RD_C  = 3'h2;
  localparam logic [2:0] OP_RESET = 3'h3;
  localparam logic [2:0] OP_NEXT  = 3'h4;
  localparam logic [2:0] OP_CLOSE = 3'h5;

  // page and block geometry
  localparam logic [9:0] LAST_COL   = 10'h20F; // 528 bytes per page
  localparam logic [1:0] BASE_A     = 2'h0;    // column 0
  localparam logic [1:0] BASE_B     = 2'h1;    // column 256
  localparam logic [1:0] BASE_C     = 2'h2;    // column 512, 16 bytes
  localparam logic [4:0] LAST_PAGE  = 5'h1F;   // 32 pages per block

  // register map, byte addresses
  localparam logic [11:0] REG_CMD    = 12'h000;
  localparam logic [11:0] REG_ADDR   = 12'h004;
  localparam logic [11:0] REG_STATUS = 12'h008;
  localparam logic [23:0] ADDR_RST   = 24'h000000;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLV   = 2'h2;

  // status bit positions
  localparam int ST_BUSY = 0;
  localparam int ST_RDY  = 1;
  localparam int ST_OPEN = 2;
  localparam int ST_END  = 3;
  localparam int ST_INIT = 4;
  localparam int ST_REF  = 5;
  localparam int ST_TMO  = 6;
  localparam int ST_DATA = 8;
  localparam int ST_COL  = 16;

  typedef struct packed {
    logic       ce_n;
    logic       cle;
    logic       ale;
    logic       we_n;
    logic       re_n;
    logic       io_oe;
    logic [7:0] io_out;
  } nrp_pins_type;

  localparam nrp_pins_type PINS_RST = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1,
                                        1'b0, 8'h00};

  typedef struct packed {
    logic       valid;
    logic [2:0] op;
  } nrp_cmd_type;

endpackage

/* File: core/nrp_axil_regs.sv */
// Purpose: AXI4-Lite slave holding the command, address and status words
// Assumes: one write and one read at most outstanding
// Notes:   a command write yields a one-cycle pulse toward the sequencer
`timescale 1ns/1ps
`default_nettype none
module nrp_axil_regs (
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic [11:0]          s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [11:0]          s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  input  wire logic [31:0]          status,
  output logic [23:0]               addr_q,
  output var nrp_pkg::nrp_cmd_type  cmd_q
);

  logic [11:0] awa_q, awa_d;
  logic        awh_q, awh_d, wh_q, wh_d, bv_q, bv_d, rv_q, rv_d;
  logic [31:0] wd_q, wd_d, rd_q, rd_d;
  logic [3:0]  ws_q, ws_d;
  logic [1:0]  br_q, br_d, rr_q, rr_d;
  logic [23:0] addr_d;
  nrp_pkg::nrp_cmd_type cmd_d;

  // word select: 0 command, 1 address, 2 status, 3 unmapped
  function automatic logic [1:0] reg_sel(input logic [11:0] a);
    logic [1:0] s;
    s = 2'h3;
    if ({a[11:2], 2'b00} == nrp_pkg::REG_CMD) s = 2'h0;
    if ({a[11:2], 2'b00} == nrp_pkg::REG_ADDR) s = 2'h1;
    if ({a[11:2], 2'b00} == nrp_pkg::REG_STATUS) s = 2'h2;
    return s;
  endfunction

  // address and data are taken in either order, held until both are in
  assign s_axi_awready = !awh_q && !bv_q;
  assign s_axi_wready  = !wh_q && !bv_q;
  assign s_axi_arready = !rv_q;
  assign s_axi_bvalid  = bv_q;
  assign s_axi_bresp   = br_q;
  assign s_axi_rvalid  = rv_q;
  assign s_axi_rresp   = rr_q;
  assign s_axi_rdata   = rd_q;

  // bus next state
  always_comb begin
    awa_d  = awa_q;
    awh_d  = awh_q;
    wd_d   = wd_q;
    ws_d   = ws_q;
    wh_d   = wh_q;
    bv_d   = bv_q;
    br_d   = br_q;
    rv_d   = rv_q;
    rr_d   = rr_q;
    rd_d   = rd_q;
    addr_d = addr_q;
    cmd_d  = '{1'b0, cmd_q.op};
    if (s_axi_awvalid && s_axi_awready) begin
      awa_d = s_axi_awaddr;
      awh_d = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      wd_d = s_axi_wdata;
      ws_d = s_axi_wstrb;
      wh_d = 1'b1;
    end
    if (awh_q && wh_q) begin
      awh_d = 1'b0;
      wh_d  = 1'b0;
      bv_d  = 1'b1;
      br_d  = nrp_pkg::RESP_OKAY;
      unique case (reg_sel(awa_q))
        2'h0: if (ws_q[0]) cmd_d = '{1'b1, wd_q[2:0]};
        2'h1: begin
          if (ws_q[0]) addr_d[7:0] = wd_q[7:0];
          if (ws_q[1]) addr_d[15:8] = wd_q[15:8];
          if (ws_q[2]) addr_d[23:16] = wd_q[23:16];
        end
        2'h2: br_d = nrp_pkg::RESP_OKAY; // status is read only
        2'h3: br_d = nrp_pkg::RESP_SLV;
      endcase
    end
    if (bv_q && s_axi_bready) bv_d = 1'b0;
    if (rv_q && s_axi_rready) rv_d = 1'b0;
    if (s_axi_arvalid && s_axi_arready) begin
      rv_d = 1'b1;
      rr_d = nrp_pkg::RESP_OKAY;
      unique case (reg_sel(s_axi_araddr))
        2'h0: rd_d = 32'h00000000;
        2'h1: rd_d = {8'h00, addr_q};
        2'h2: rd_d = status;
        2'h3: begin
          rd_d = 32'h00000000;
          rr_d = nrp_pkg::RESP_SLV;
        end
      endcase
    end
  end

  // bus registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awa_q  <= 12'h000;
      awh_q  <= 1'b0;
      wd_q   <= 32'h00000000;
      ws_q   <= 4'h0;
      wh_q   <= 1'b0;
      bv_q   <= 1'b0;
      br_q   <= nrp_pkg::RESP_OKAY;
      rv_q   <= 1'b0;
      rr_q   <= nrp_pkg::RESP_OKAY;
      rd_q   <= 32'h00000000;
      addr_q <= nrp_pkg::ADDR_RST;
      cmd_q  <= '{1'b0, 3'h0};
    end else begin
      awa_q  <= awa_d;
      awh_q  <= awh_d;
      wd_q   <= wd_d;
      ws_q   <= ws_d;
      wh_q   <= wh_d;
      bv_q   <= bv_d;
      br_q   <= br_d;
      rv_q   <= rv_d;
      rr_q   <= rr_d;
      rd_q   <= rd_d;
      addr_q <= addr_d;
      cmd_q  <= cmd_d;
    end
  end

endmodule
`default_nettype wire

/* File: core/nrp_host.sv */
// Purpose: host sequencer that drives a strobe-driven byte-wide ROM
// Assumes: pins are asynchronous to aclk and pass two flip-flops
// Notes:   software issues reads, steps bytes and resets by register
// Contract
// - commands, addresses, data share 8-bit bus; flags pick cycle type
// - host sends no command except reset while device is busy
// - read address: bits 7..0, 16..9, then 23..17 with top bit zero
// - mode C first address cycle carries only bits 3..0
// - host issues only the three read codes and reset
// - after power-on chip select high, then reset before any read
`timescale 1ns/1ps
`default_nettype none
module nrp_host (
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic [11:0]          s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [11:0]          s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  output var nrp_pkg::nrp_pins_type pins_q,
  input  wire logic [7:0]           io_in,
  input  wire logic                 ready_busy_n
);
  typedef enum logic [6:0] {
    S_IDLE  = 7'h01,
    S_WE_LO = 7'h02,
    S_WE_HI = 7'h04,
    S_WAIT  = 7'h08,
    S_RDY   = 7'h10,
    S_RE_LO = 7'h20,
    S_RE_HI = 7'h40
  } nrp_state_type;
  nrp_state_type        state_q, state_d;
  nrp_pkg::nrp_pins_type pins_d;
  nrp_pkg::nrp_cmd_type  cmd;
  logic [23:0] addr;
  logic [31:0] status;
  logic [8:0]  meta_q, sync_q;
  logic        rb_s;
  logic [7:0]  io_s;
  logic [9:0]  cnt_q, cnt_d, col_q, col_d;
  logic [4:0]  page_q, page_d;
  logic [2:0]  mode_q, mode_d;
  logic [1:0]  idx_q, idx_d;
  logic [7:0]  data_q, data_d;
  logic        rdy_q, rdy_d, open_q, open_d, end_q, end_d;
  logic        init_q, init_d, ref_q, ref_d, tmo_q, tmo_d;
  nrp_axil_regs u_regs (
    .aclk          (aclk),            .aresetn       (aresetn),
    .s_axi_awaddr  (s_axi_awaddr),    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),   .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),     .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),   .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),     .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),    .status        (status),
    .addr_q        (addr),            .cmd_q         (cmd)
  );
  // two-flop synchronisers on the ready line and the data bus
  for (genvar i = 0; i < 9; i++) begin : g_sync
    always_ff @(posedge aclk) begin
      meta_q[i] <= aresetn && ((i == 8) ? ready_busy_n : io_in[i % 8]);
      sync_q[i] <= aresetn && meta_q[i];
    end
  end
  assign rb_s = sync_q[8];
  assign io_s = sync_q[7:0];
  assign status = {6'h00, col_q, data_q, 1'b0, tmo_q, ref_q, init_q,
                   end_q, open_q, rb_s, state_q != S_IDLE};
  // only the four legal codes can ever leave the host
  function automatic logic [7:0] cmd_code(input logic [2:0] m);
    logic [7:0] c;
    c = nrp_pkg::CMD_RESET;
    if (m == nrp_pkg::OP_RD_A) c = nrp_pkg::CMD_READ_A;
    if (m == nrp_pkg::OP_RD_B) c = nrp_pkg::CMD_READ_B;
    if (m == nrp_pkg::OP_RD_C) c = nrp_pkg::CMD_READ_C;
    return c;
  endfunction
  // byte of the command sequence; bit 8 of the address is never sent
  function automatic logic [7:0] seq_byte(input logic [1:0] i,
                                          input logic [2:0] m,
                                          input logic [23:0] a);
    logic [7:0] b;
    b = 8'h00;
    unique case (i)
      2'd0: b = cmd_code(m);
      2'd1: b = (m == nrp_pkg::OP_RD_C) ? {4'h0, a[3:0]} : a[7:0];
      2'd2: b = a[16:9];
      2'd3: b = {1'b0, a[23:17]};
    endcase
    return b;
  endfunction
  // sequencer next state
  always_comb begin
    state_d = state_q;
    pins_d  = pins_q;
    cnt_d   = cnt_q - 10'h001;
    col_d   = col_q;
    page_d  = page_q;
    mode_d  = mode_q;
    idx_d   = idx_q;
    data_d  = data_q;
    {rdy_d, open_d, end_d, init_d, ref_d, tmo_d} =
      {rdy_q, open_q, end_q, init_q, ref_q, tmo_q};
    unique case (state_q)
      S_IDLE: begin
        cnt_d = cnt_q;
        if (cmd.valid) begin
          ref_d = 1'b0;
          if (cmd.op == nrp_pkg::OP_RESET ||
              (cmd.op <= nrp_pkg::OP_RD_C && init_q && rb_s)) begin
            // reset goes out even when busy; reads wait for ready
            mode_d  = cmd.op;
            idx_d   = 2'd0;
            open_d  = 1'b0;
            pins_d  = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1,
                        cmd_code(cmd.op)};
            cnt_d   = nrp_pkg::C_WP;
            state_d = S_WE_LO;
          end else if (cmd.op == nrp_pkg::OP_NEXT && open_q && !end_q &&
                       rb_s) begin
            pins_d.re_n  = 1'b0;
            pins_d.io_oe = 1'b0;
            cnt_d        = nrp_pkg::C_RE;
            state_d      = S_RE_LO;
          end else if (cmd.op == nrp_pkg::OP_CLOSE) begin
            pins_d.ce_n = 1'b1;
            open_d      = 1'b0;
          end else ref_d = 1'b1;
        end
      end
      S_WE_LO: if (cnt_q == 10'h001) begin
        pins_d.we_n = 1'b1;
        cnt_d       = nrp_pkg::C_WH;
        state_d     = S_WE_HI;
      end
      S_WE_HI: if (cnt_q == 10'h001) begin
        if (mode_q == nrp_pkg::OP_RESET || idx_q == 2'd3) begin
          pins_d.cle   = 1'b0;
          pins_d.ale   = 1'b0;
          pins_d.io_oe = 1'b0;
          rdy_d        = 1'b1;
          cnt_d        = nrp_pkg::C_WB;
          state_d      = S_WAIT;
          if (mode_q != nrp_pkg::OP_RESET) begin
            // byte position inside page and block, by area
            open_d = 1'b1;
            end_d  = 1'b0;
            page_d = addr[13:9];
            unique case (mode_q)
              nrp_pkg::OP_RD_B: col_d = {nrp_pkg::BASE_B, addr[7:0]};
              nrp_pkg::OP_RD_C: col_d = {nrp_pkg::BASE_C, 4'h0, addr[3:0]};
              default:          col_d = {nrp_pkg::BASE_A, addr[7:0]};
            endcase
          end
        end else begin
          idx_d   = idx_q + 2'd1;
          pins_d  = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1,
                      seq_byte(idx_q + 2'd1, mode_q, addr)};
          cnt_d   = nrp_pkg::C_WP;
          state_d = S_WE_LO;
        end
      end
      S_WAIT: if (cnt_q == 10'h001) begin
        // the busy window or the ready-to-strobe wait has passed; after a busy window the ready line tells the truth
        cnt_d   = nrp_pkg::C_R;
        state_d = rdy_q ? S_RDY : S_IDLE;
      end
      S_RDY: begin
        if (rb_s) begin
          rdy_d   = 1'b0;
          cnt_d   = nrp_pkg::C_RR;
          state_d = S_WAIT;
          if (mode_q == nrp_pkg::OP_RESET) begin
            init_d      = 1'b1;
            pins_d.ce_n = 1'b1;
          end
        end else if (cnt_q == 10'h001) begin
          // a fetch or reset that never ends: give up and free the chip
          tmo_d       = 1'b1;
          open_d      = 1'b0;
          rdy_d       = 1'b0;
          pins_d.ce_n = 1'b1;
          state_d     = S_IDLE;
        end
      end
      S_RE_LO: if (cnt_q == 10'h001) begin
        data_d      = io_s;
        pins_d.re_n = 1'b1;
        cnt_d       = nrp_pkg::C_REH;
        state_d     = S_RE_HI;
      end
      S_RE_HI: if (cnt_q == 10'h001) begin
        state_d = S_IDLE;
        col_d   = col_q + 10'h001;
        if (col_q == nrp_pkg::LAST_COL) begin
          col_d = 10'h000;
          if (page_q == nrp_pkg::LAST_PAGE) end_d = 1'b1;
          else begin
            page_d  = page_q + 5'h01;
            rdy_d   = 1'b1;
            cnt_d   = nrp_pkg::C_RB;
            state_d = S_WAIT;
          end
        end
      end
      default: state_d = S_IDLE;
    endcase
  end
  // sequencer registers; chip select stays high out of reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= S_IDLE;
      pins_q  <= nrp_pkg::PINS_RST;
      cnt_q   <= 10'h000;
      col_q   <= 10'h000;
      page_q  <= 5'h00;
      mode_q  <= nrp_pkg::OP_RESET;
      idx_q   <= 2'd0;
      data_q  <= 8'h00;
      {rdy_q, open_q, end_q, init_q, ref_q, tmo_q} <= 6'h00;
    end else begin
      state_q <= state_d;
      pins_q  <= pins_d;
      cnt_q   <= cnt_d;
      col_q   <= col_d;
      page_q  <= page_d;
      mode_q  <= mode_d;
      idx_q   <= idx_d;
      data_q  <= data_d;
      {rdy_q, open_q, end_q, init_q, ref_q, tmo_q} <=
        {rdy_d, open_d, end_d, init_d, ref_d, tmo_d};
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_latch_cycle: assert property (!pins_q.we_n |-> !pins_q.ce_n &&
    pins_q.re_n && (pins_q.cle ^ pins_q.ale))
    else $error("input strobe low outside a latch cycle");
  a_we_width: assert property ($fell(pins_q.we_n) |=>
    !pins_q.we_n [*3] ##1 pins_q.we_n [*3])
    else $error("input strobe pulse timing wrong");
  a_read_float: assert property (!pins_q.re_n |-> !pins_q.io_oe &&
    !pins_q.ce_n && !pins_q.cle && !pins_q.ale)
    else $error("host drives bus during serial read");
  a_busy_cmd: assert property ($fell(pins_q.we_n) && pins_q.cle &&
    pins_q.io_out != nrp_pkg::CMD_RESET |-> $past(rb_s))
    else $error("command other than reset sent while busy");
  a_code_legal: assert property ($fell(pins_q.we_n) && pins_q.cle |->
    pins_q.io_out inside {8'h00, 8'h01, 8'h50, 8'hFF})
    else $error("illegal command code");
  a_reset_first: assert property ($fell(pins_q.we_n) && pins_q.cle &&
    !init_q |-> pins_q.io_out == nrp_pkg::CMD_RESET)
    else $error("read before the first reset");
  a_third_top: assert property ($fell(pins_q.we_n) && idx_q == 2'd3
    |-> pins_q.ale && pins_q.io_out == {1'b0, addr[23:17]})
    else $error("third address cycle wrong");
  a_modec_low: assert property ($fell(pins_q.we_n) && idx_q == 2'd1 &&
    mode_q == nrp_pkg::OP_RD_C |-> pins_q.io_out == {4'h0, addr[3:0]})
    else $error("mode C first address cycle wrong");
  a_page_busy: assert property (state_q == S_RE_HI && cnt_q == 10'h001 &&
    col_q == nrp_pkg::LAST_COL && page_q != nrp_pkg::LAST_PAGE
    |=> state_q == S_WAIT ##25 state_q == S_RDY)
    else $error("no busy wait after page end");
  a_re_ready: assert property ($fell(pins_q.re_n) |-> $past(rb_s))
    else $error("output strobe while device busy");

endmodule
`default_nettype wire

/* File: dv/nrp_dev_model.sv */
// Purpose: behavioural model of the strobe-driven read-only byte device
// Assumes: the host keeps the documented pin sequences
// Notes:   fetch time is a parameter; the bus shows ~last when released
`timescale 1ns/1ps
`default_nettype none
module nrp_dev_model #(
  parameter int FETCH_NS = 3000
) (
  input  wire nrp_pkg::nrp_pins_type pins,
  output logic [7:0]                 io_drv,
  output logic                       ready_busy_n
);
  logic [7:0] mode, a0, a1, last, cur;
  logic [9:0] col;
  logic [4:0] page;
  int         acnt;

  // busy window covers fetch and reset alike
  task automatic fetch();
    ready_busy_n = 1'b0;
    #(FETCH_NS);
    ready_busy_n = 1'b1;
  endtask

  initial begin
    ready_busy_n = 1'b1;
    acnt = 3;
    col = 10'h000;
    page = 5'h00;
    mode = 8'h00;
    last = 8'h00;
  end

  // redundancy reads all ones; main bytes follow a column pattern
  assign cur = (col >= 10'h200) ? 8'hFF : col[8:1] ^ {3'h0, page};
  // a released bus shows the inverse so no stale value passes
  assign io_drv = (!pins.ce_n && !pins.re_n) ? cur : ~last;

  // command and address bytes are taken on the input strobe rising
  always @(posedge pins.we_n) begin
    if (!pins.ce_n && pins.cle && pins.io_out == 8'hFF) begin
      acnt = 3;
      fetch();
    end else if (!pins.ce_n && pins.cle && ready_busy_n) begin
      mode = pins.io_out;
      acnt = 0;
    end else if (!pins.ce_n && pins.ale && acnt < 3) begin
      if (acnt == 0) a0 = pins.io_out;
      else if (acnt == 1) a1 = pins.io_out;
      acnt++;
      if (acnt == 3) begin
        // area from the command, bit 8 never from the bus
        col = (mode == 8'h50) ? 10'(10'h200 + a0[3:0])
                              : {1'b0, mode[0], a0};
        page = a1[4:0];
        fetch();
      end
    end
  end

  // sequential read fetches the next page at each page end except the block's last; after the block's last byte it wraps to column 0
  always @(posedge pins.re_n) begin
    if (!pins.ce_n) begin
      last = cur;
      if (col == 10'd527) begin
        col = 10'h000;
        if (page != 5'h1F) begin
          page++;
          fetch();
        end
      end else col++;
    end
  end
endmodule
`default_nettype wire

/* File: dv/nrp_host_tb_top.sv */
// Purpose: self-checking bench for the host controller over AXI4-Lite
// Assumes: device model answers within its fetch parameter
// Notes:   handshakes are judged at the falling edge before each take
`timescale 1ns/1ps
`default_nettype none
module nrp_host_tb_top;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, ready_busy_n;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, st;
  logic [1:0]  bresp, rresp, rs, wrsp;
  logic [7:0]  io_in, io_drv;
  nrp_pkg::nrp_pins_type pins;
  int fail_count, samples_checked;
  logic [2:0] ops [3] = '{nrp_pkg::OP_RD_A, nrp_pkg::OP_RD_B,
                          nrp_pkg::OP_RD_C};
  logic [9:0] cols [3] = '{10'h037, 10'h137, 10'h207};

  nrp_host dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .pins_q(pins), .io_in(io_in),
    .ready_busy_n(ready_busy_n));
  nrp_dev_model dev (.pins(pins), .io_drv(io_drv),
    .ready_busy_n(ready_busy_n));
  // shared bus: host drives only while its enable is high
  assign io_in = pins.io_oe ? pins.io_out : io_drv;

  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic ah, wh, bh;
    ah = 0; wh = 0; bh = 0;
    awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
    while (!bh) begin
      @(negedge aclk);
      ah = awvalid && awready; wh = wvalid && wready; bh = bvalid;
      if (bvalid) wrsp = bresp;
      @(posedge aclk);
      if (ah) awvalid <= 0;
      if (wh) wvalid <= 0;
      if (bh) bready <= 0;
    end
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    logic hit;
    hit = 0;
    araddr <= a; arvalid <= 1; rready <= 1;
    while (!hit) begin
      @(negedge aclk);
      if (arvalid && arready) begin @(posedge aclk); arvalid <= 0; end
      else begin hit = rvalid; d = rdata; r = rresp; @(posedge aclk); end
    end
    rready <= 0;
    @(posedge aclk); // an edge between reads so rready is set once a step
  endtask

  task automatic idle();
    int n;
    for (n = 0; n < 3000; n++) begin
      rd(nrp_pkg::REG_STATUS, st, rs);
      if (st[nrp_pkg::ST_BUSY] === 1'b0) break;
    end
    if (n == 3000) chk(st[nrp_pkg::ST_BUSY], 1'b0);
  endtask

  task automatic op(input logic [2:0] o);
    wr(nrp_pkg::REG_CMD, {29'h0, o});
    idle();
  endtask

  function automatic logic [7:0] exp_byte(input logic [9:0] c,
                                          input logic [4:0] p);
    return (c >= 10'h200) ? 8'hFF : c[8:1] ^ {3'h0, p};
  endfunction

  task automatic end_sim();
    $display("checked %0d errors %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    #500us;
    fail_count++;
    end_sim();
  end

  initial begin
    fail_count = 0; samples_checked = 0; aresetn = 0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    awaddr = '0; araddr = '0; wdata = '0;
    repeat (6) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    rd(12'h00C, st, rs);
    chk(rs, nrp_pkg::RESP_SLV); // unmapped place
    op(nrp_pkg::OP_RD_A);
    chk(st[nrp_pkg::ST_REF], 1'b1);
    op(nrp_pkg::OP_RESET);
    chk(st[nrp_pkg::ST_INIT], 1'b1);
    wr(nrp_pkg::REG_ADDR, 32'h00000A37);
    chk(wrsp, nrp_pkg::RESP_OKAY);
    rd(nrp_pkg::REG_ADDR, st, rs);
    chk(st, 32'h00000A37);
    for (int i = 0; i < 3; i++) begin
      op(ops[i]);
      op(nrp_pkg::OP_NEXT);
      chk(st[15:8], exp_byte(cols[i], 5'h05));
    end
    wr(nrp_pkg::REG_ADDR, 32'h00000A0F);
    op(nrp_pkg::OP_RD_C);
    op(nrp_pkg::OP_NEXT);
    chk(st[15:8], 8'hFF);
    op(nrp_pkg::OP_NEXT);
    chk(st[15:8], exp_byte(10'h000, 5'h06));
    wr(nrp_pkg::REG_ADDR, 32'h00003E0F);
    op(nrp_pkg::OP_RD_C);
    op(nrp_pkg::OP_NEXT);
    op(nrp_pkg::OP_NEXT);
    chk(st[nrp_pkg::ST_END], 1'b1);
    op(3'h7);
    chk(st[nrp_pkg::ST_REF], 1'b1);
    op(nrp_pkg::OP_CLOSE);
    chk(st[nrp_pkg::ST_OPEN], 1'b0);
    chk(pins.ce_n, 1'b1);
    end_sim();
  end
endmodule
`default_nettype wire
